// [common/scb_pkg.sv]
// package for the four-channel serial byte buffer block
// used by the channel buffer top; the fifo leaf takes its own parameters
package scb_pkg;
  // ----------------------------------------------------------------
  // geometry
  // ----------------------------------------------------------------
  localparam int SCB_CHANNELS = 4;
  localparam int SCB_CH_W = 2;
  localparam int SCB_DATA_W = 8;
  localparam int SCB_DEPTH = 16;
  localparam int SCB_PTR_W = 4;
  localparam int SCB_CNT_W = 5;
  // ----------------------------------------------------------------
  // buffer selectors for clear and queries
  // ----------------------------------------------------------------
  localparam logic [1:0] SCB_SEL_RECV = 2'h0;
  localparam logic [1:0] SCB_SEL_SEND = 2'h1;
  localparam logic [1:0] SCB_SEL_BOTH = 2'h2;
  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [SCB_CNT_W-1:0] SCB_CNT_RST = 5'h00;
  localparam logic [SCB_PTR_W-1:0] SCB_PTR_RST = 4'h0;
  localparam logic [SCB_DATA_W-1:0] SCB_DATA_RST = 8'h00;
  // usable capacity is one slot short of the configured size
  localparam logic [SCB_CNT_W-1:0] SCB_USABLE = 5'(SCB_DEPTH - 1);
  // query kinds
  typedef enum logic [1:0] {SCB_Q_LEN, SCB_Q_FREE} scb_query_t;
endpackage : scb_pkg

// [rtl/scb_channel_buffers.sv]
// four serial channels, each with a receive and a send byte fifo
// assumes one clock domain; line side and program side are same-clock logic
`timescale 1ns/100ps
// Behaviour
// - four channels 0..3, each with its own receive and send fifo
// - clear selector 0 receive, 1 send, 2 both; held bytes are dropped
// - free query selector 0 reports receive free slots, 1 send free slots
// - empty buffer reports free space of size minus one
// - length query reports bytes held, zero when empty
// - full receive buffer refuses incoming bytes until space frees
// - peek returns oldest receive byte without removal; read removes it
module scb_channel_buffers (
  input wire logic clock,
  input wire logic rst,
  input wire logic clkEn,
  // line side, receive direction
  input wire logic [scb_pkg::SCB_CHANNELS-1:0] lineRxValid,
  input wire logic [scb_pkg::SCB_CHANNELS*scb_pkg::SCB_DATA_W-1:0] lineRxData,
  output logic [scb_pkg::SCB_CHANNELS-1:0] lineRxReady,
  // line side, send direction
  output logic [scb_pkg::SCB_CHANNELS-1:0] lineTxValid,
  output logic [scb_pkg::SCB_CHANNELS*scb_pkg::SCB_DATA_W-1:0] lineTxData,
  input wire logic [scb_pkg::SCB_CHANNELS-1:0] lineTxReady,
  // program side: write a byte into a send fifo
  input wire logic putValid,
  input wire logic [scb_pkg::SCB_CH_W-1:0] putChan,
  input wire logic [scb_pkg::SCB_DATA_W-1:0] putData,
  output logic putReady,
  // program side: read (remove) or peek the oldest receive byte
  input wire logic getReq,
  input wire logic peekReq,
  input wire logic [scb_pkg::SCB_CH_W-1:0] getChan,
  output logic getDone,
  output logic getHit,
  output logic [scb_pkg::SCB_DATA_W-1:0] getData,
  // program side: clear
  input wire logic clrReq,
  input wire logic [scb_pkg::SCB_CH_W-1:0] clrChan,
  input wire logic [1:0] clrSel,
  // program side: length and free queries
  input wire logic qryReq,
  input wire logic qryFree,
  input wire logic [scb_pkg::SCB_CH_W-1:0] qryChan,
  input wire logic [1:0] qrySel,
  output logic qryDone,
  output logic [scb_pkg::SCB_CNT_W-1:0] qryCount,
  // per-channel receive event
  output logic [scb_pkg::SCB_CHANNELS-1:0] receiveEvent
);
  import scb_pkg::*;

  logic [SCB_CHANNELS-1:0] rxInReady;
  logic [SCB_CHANNELS-1:0] rxOutValid;
  logic [SCB_CHANNELS-1:0] rxPop;
  logic [SCB_CHANNELS-1:0] rxFlush;
  logic [SCB_CHANNELS-1:0] txInReady;
  logic [SCB_CHANNELS-1:0] txPush;
  logic [SCB_CHANNELS-1:0] txFlush;
  logic [SCB_CHANNELS-1:0] txOutValid;
  logic [SCB_DATA_W-1:0] rxHead [SCB_CHANNELS];
  logic [SCB_DATA_W-1:0] txHead [SCB_CHANNELS];
  logic [SCB_CNT_W-1:0] rxLevel [SCB_CHANNELS];
  logic [SCB_CNT_W-1:0] txLevel [SCB_CHANNELS];
  logic [SCB_CHANNELS-1:0] txTake;
  logic [SCB_CHANNELS-1:0] txValid_ff;
  logic [SCB_CHANNELS*SCB_DATA_W-1:0] txData_ff;
  logic [SCB_CHANNELS-1:0] rxReady_ff;
  logic [SCB_CHANNELS-1:0] event_ff;
  logic putReady_ff;
  logic getDone_ff;
  logic getHit_ff;
  logic [SCB_DATA_W-1:0] getData_ff;
  logic qryDone_ff;
  logic [SCB_CNT_W-1:0] qryCount_ff;
  logic [SCB_CNT_W-1:0] selLevel;

  // ----------------------------------------------------------------
  // per-channel fifo pairs and their strobes
  // ----------------------------------------------------------------
  for (genvar c = 0; c < SCB_CHANNELS; c++) begin : gChan
    // clear decode
    assign rxFlush[c] = clrReq && (clrChan == c) &&
                        (clrSel == SCB_SEL_RECV || clrSel == SCB_SEL_BOTH);
    assign txFlush[c] = clrReq && (clrChan == c) &&
                        (clrSel == SCB_SEL_SEND || clrSel == SCB_SEL_BOTH);
    // only a plain read removes a byte; peek leaves it
    assign rxPop[c] = getReq && !peekReq && (getChan == c);
    assign txPush[c] = putValid && putReady_ff && (putChan == c);
    // registered line byte leaves when line takes it or slot is empty
    assign txTake[c] = txOutValid[c] && (!txValid_ff[c] || lineTxReady[c]) && !txFlush[c];

    scb_fifo #(.WIDTH(SCB_DATA_W), .DEPTH(SCB_DEPTH)) uRx (
      .clock(clock),
      .rst(rst),
      .clkEn(clkEn),
      .flush(rxFlush[c]),
      .inValid(lineRxValid[c] && rxReady_ff[c]),
      .inReady(rxInReady[c]),
      .inData(lineRxData[c*SCB_DATA_W +: SCB_DATA_W]),
      .outValid(rxOutValid[c]),
      .outReady(rxPop[c]),
      .outData(rxHead[c]),
      .level(rxLevel[c])
    );

    scb_fifo #(.WIDTH(SCB_DATA_W), .DEPTH(SCB_DEPTH)) uTx (
      .clock(clock),
      .rst(rst),
      .clkEn(clkEn),
      .flush(txFlush[c]),
      .inValid(txPush[c]),
      .inReady(txInReady[c]),
      .inData(putData),
      .outValid(txOutValid[c]),
      .outReady(txTake[c]),
      .outData(txHead[c]),
      .level(txLevel[c])
    );

    // line-side receive ready: low while full, so no byte is dropped
    always_ff @(posedge clock) begin
      if (rst) begin
        rxReady_ff[c] <= 1'h0;
      end else if (clkEn) begin
        rxReady_ff[c] <= (rxLevel[c] + SCB_CNT_W'(lineRxValid[c] && rxReady_ff[c])
                          < SCB_USABLE) && !rxFlush[c];
      end
    end

    // receive event pulses one cycle per stored byte
    always_ff @(posedge clock) begin
      if (rst) begin
        event_ff[c] <= 1'h0;
      end else if (clkEn) begin
        event_ff[c] <= lineRxValid[c] && rxReady_ff[c] && rxInReady[c];
      end
    end

    // send output stage, cleared along with the send buffer
    always_ff @(posedge clock) begin
      if (rst) begin
        txValid_ff[c] <= 1'h0;
        txData_ff[c*SCB_DATA_W +: SCB_DATA_W] <= SCB_DATA_RST;
      end else if (clkEn) begin
        if (txFlush[c]) begin
          txValid_ff[c] <= 1'h0;
        end else if (txTake[c]) begin
          txValid_ff[c] <= 1'h1;
          txData_ff[c*SCB_DATA_W +: SCB_DATA_W] <= txHead[c];
        end else if (lineTxReady[c]) begin
          txValid_ff[c] <= 1'h0;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // program side answers
  // ----------------------------------------------------------------
  // put ready reflects room in the addressed send fifo
  always_ff @(posedge clock) begin
    if (rst) begin
      putReady_ff <= 1'h0;
    end else if (clkEn) begin
      putReady_ff <= txInReady[putChan] && !(putValid && putReady_ff) &&
                     !txFlush[putChan];
    end
  end

  // read or peek answer, one cycle after the request
  always_ff @(posedge clock) begin
    if (rst) begin
      getDone_ff <= 1'h0;
      getHit_ff <= 1'h0;
      getData_ff <= SCB_DATA_RST;
    end else if (clkEn) begin
      getDone_ff <= getReq;
      getHit_ff <= getReq && rxOutValid[getChan];
      if (getReq) begin
        getData_ff <= rxOutValid[getChan] ? rxHead[getChan] : SCB_DATA_RST;
      end
    end
  end

  // level of the buffer the query names
  always_comb begin
    selLevel = (qrySel == SCB_SEL_SEND) ? txLevel[qryChan] : rxLevel[qryChan];
  end

  // length or free count, one cycle after the request
  always_ff @(posedge clock) begin
    if (rst) begin
      qryDone_ff <= 1'h0;
      qryCount_ff <= SCB_CNT_RST;
    end else if (clkEn) begin
      qryDone_ff <= qryReq;
      if (qryReq) begin
        if (qryFree) begin
          qryCount_ff <= SCB_CNT_W'(SCB_USABLE - selLevel);
        end else begin
          qryCount_ff <= selLevel;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // outputs, each straight from a register
  // ----------------------------------------------------------------
  assign lineRxReady = rxReady_ff;
  assign lineTxValid = txValid_ff;
  assign lineTxData = txData_ff;
  assign receiveEvent = event_ff;
  assign putReady = putReady_ff;
  assign getDone = getDone_ff;
  assign getHit = getHit_ff;
  assign getData = getData_ff;
  assign qryDone = qryDone_ff;
  assign qryCount = qryCount_ff;
endmodule : scb_channel_buffers

// [rtl/scb_fifo.sv]
// one byte fifo with valid/ready on both sides, synchronous flush and peek
// assumes one clock, synchronous active high reset, clock enable
`timescale 1ns/100ps
module scb_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic clkEn,
  input wire logic flush,
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData,
  output logic [$clog2(DEPTH):0] level
);
  localparam int PW = $clog2(DEPTH);
  localparam int CW = PW + 1;
  localparam logic [CW-1:0] CAP = CW'(DEPTH - 1);
  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [PW-1:0] wrPtr_ff;
  logic [PW-1:0] rdPtr_ff;
  logic [CW-1:0] cnt_ff;
  logic doWr;
  logic doRd;
  // ----------------------------------------------------------------
  // handshakes: one slot kept unused so capacity is depth minus one
  // ----------------------------------------------------------------
  assign inReady = (cnt_ff < CAP) && !flush;
  assign outValid = (cnt_ff != '0);
  assign outData = mem_ff[rdPtr_ff];
  assign level = cnt_ff;
  assign doWr = inValid && inReady;
  assign doRd = outValid && outReady && !flush;
  // storage
  always_ff @(posedge clock) begin
    if (clkEn && doWr) begin
      mem_ff[wrPtr_ff] <= inData;
    end
  end
  // pointers and count, flush discards everything held
  always_ff @(posedge clock) begin
    if (rst) begin
      wrPtr_ff <= '0;
      rdPtr_ff <= '0;
      cnt_ff <= '0;
    end else if (clkEn) begin
      if (flush) begin
        wrPtr_ff <= '0;
        rdPtr_ff <= '0;
        cnt_ff <= '0;
      end else begin
        if (doWr) begin
          wrPtr_ff <= PW'(wrPtr_ff + 1'h1);
        end
        if (doRd) begin
          rdPtr_ff <= PW'(rdPtr_ff + 1'h1);
        end
        cnt_ff <= CW'(cnt_ff + CW'(doWr) - CW'(doRd));
      end
    end
  end
endmodule : scb_fifo

// [sim/scb_channel_buffers_chk.sv]
// assertions on the ports of the four-channel byte buffer top
// assumes one clock and a synchronous active high reset
`timescale 1ns/100ps
module scb_channel_buffers_chk (
  input wire logic clock,
  input wire logic rst,
  input wire logic clkEn,
  input wire logic [3:0] lineRxValid,
  input wire logic [3:0] lineRxReady,
  input wire logic [3:0] lineTxValid,
  input wire logic [31:0] lineTxData,
  input wire logic [3:0] lineTxReady,
  input wire logic putValid,
  input wire logic putReady,
  input wire logic getReq,
  input wire logic getDone,
  input wire logic getHit,
  input wire logic [7:0] getData,
  input wire logic clrReq,
  input wire logic qryReq,
  input wire logic qryFree,
  input wire logic qryDone,
  input wire logic [4:0] qryCount,
  input wire logic [3:0] receiveEvent
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  // answers, events and holds at the ports
  a_get_answer: assert property (clkEn && getReq |=> getDone)
    else $error("get not answered");
  a_qry_answer: assert property (clkEn && qryReq |=> qryDone)
    else $error("query not answered");
  a_rx_event: assert property (clkEn |=> receiveEvent == $past(lineRxValid & lineRxReady))
    else $error("receive event wrong");
  a_miss_zero: assert property (getDone && !getHit |-> getData == 8'h00)
    else $error("empty read gave data");
  a_put_gap: assert property (clkEn && putValid && putReady |=> !putReady)
    else $error("put ready stayed high");
  a_tx_hold: assert property (clkEn && lineTxValid[0] && !lineTxReady[0] && !clrReq
    |=> lineTxValid[0] && $stable(lineTxData[7:0]))
    else $error("send byte not held");
  a_free_max: assert property (qryDone && $past(qryFree) |-> qryCount <= 5'h0F)
    else $error("free count too large");
  a_reset_quiet: assert property (disable iff (1'h0) rst && clkEn
    |=> receiveEvent == 4'h0 && !getDone && !qryDone && lineTxValid == 4'h0)
    else $error("outputs active after reset");
endmodule : scb_channel_buffers_chk
bind scb_channel_buffers scb_channel_buffers_chk i_chk (.*);

// [sim/scb_channel_buffers_test.sv]
// self-checking bench for the four-channel byte buffer
// assumes the line model beside the design and the bound checker
`timescale 1ns/100ps
module scb_channel_buffers_test;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic clkEn = 1'h1;
  logic putValid = 1'b0, getReq = 1'b0, peekReq = 1'b0, clrReq = 1'b0;
  logic qryReq = 1'b0, qryFree = 1'b0;
  logic [1:0] putChan = 2'h0, getChan = 2'h0, clrChan = 2'h0;
  logic [1:0] clrSel = 2'h0, qryChan = 2'h0, qrySel = 2'h0;
  logic [7:0] putData = 8'h00, getData;
  logic [3:0] lineRxValid, lineRxReady, lineTxValid, lineTxReady, receiveEvent;
  logic [31:0] lineRxData, lineTxData;
  logic putReady, getDone, getHit, qryDone;
  logic [4:0] qryCount;
  logic [8:0] expGet[$], expQry[$];
  logic [7:0] expTx[4][$];
  logic [7:0] b[16];
  int err_total = 0, tests_run = 0, cycles = 0, rxSeen = 0, c;
  bit ok;
  initial forever #5 clock = ~clock;
  scb_channel_buffers i_dut (.*);
  scb_line_model i_line (.*);
  task automatic chk(input logic [8:0] seen, input logic [8:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_total++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : give_verdict
  // k: 0 get or peek, 1 query, 2 clear, 3 idle
  task automatic cmd(input int k, input int ch, input int s, input bit f, input logic [8:0] e);
    getReq <= (k == 0);
    qryReq <= (k == 1);
    clrReq <= (k == 2);
    peekReq <= f;
    qryFree <= f;
    getChan <= 2'(ch);
    qryChan <= 2'(ch);
    clrChan <= 2'(ch);
    qrySel <= 2'(s);
    clrSel <= 2'(s);
    if (k == 0) expGet.push_back(e);
    if (k == 1) expQry.push_back(e);
    @(posedge clock);
  endtask : cmd
  // one byte into a send fifo, held until taken or for at most 40 cycles
  task automatic put(input int ch, input logic [7:0] d);
    int n;
    n = 0;
    putValid <= 1'b1;
    putChan <= 2'(ch);
    putData <= d;
    expTx[ch].push_back(d);
    do begin
      @(posedge clock);
      n++;
    end while (putReady !== 1'b1 && n < 40);
    putValid <= 1'b0;
    @(posedge clock);
  endtask : put
  // wait until every expected send byte has left, bounded
  task automatic drain();
    for (int n = 0; n < 300; n++) begin
      if (expTx[0].size() + expTx[1].size() + expTx[2].size() + expTx[3].size() == 0) break;
      @(posedge clock);
    end
  endtask : drain
  // watcher: compares each answer with the oldest note
  always @(posedge clock) begin
    if (getDone === 1'b1) chk({getHit, getData}, expGet.pop_front());
    if (qryDone === 1'b1) chk(9'(qryCount), expQry.pop_front());
    // every receive event pulse is counted once
    rxSeen += $countones(receiveEvent);
    for (int i = 0; i < 4; i++)
      if (lineTxValid[i] === 1'b1 && lineTxReady[i] === 1'b1)
        chk(9'(lineTxData[8*i+:8]), 9'(expTx[i].pop_front()));
  end
  // run limit
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      err_total++;
      give_verdict();
    end
  end
  initial begin
    c = $urandom(26927);
    repeat (3) @(posedge clock);
    rst <= 1'b0;
    repeat (2) @(posedge clock);
    for (int ch = 0; ch < 4; ch++)
      for (int s = 0; s < 3; s++) begin
        cmd(1, ch, s, 1'b1, 9'h00F);
        cmd(1, ch, s, 1'b0, 9'h000);
      end
    cmd(3, 0, 0, 1'b0, 9'h000);
    // a query held while the clock enable is low is answered once, after it rises
    clkEn <= 1'b0;
    cmd(1, 0, 0, 1'b0, 9'h000);
    repeat (3) @(posedge clock);
    chk(9'(qryDone), 9'h000);
    clkEn <= 1'b1;
    @(posedge clock);
    cmd(3, 0, 0, 1'b0, 9'h000);
    c = $urandom_range(3);
    for (int i = 0; i < 16; i++) begin
      b[i] = 8'($urandom);
      i_line.offer(c, b[i], ok);
      chk(9'(ok), 9'(i < 15));
    end
    cmd(1, c, 0, 1'b0, 9'h00F);
    cmd(1, c, 0, 1'b1, 9'h000);
    cmd(0, c, 0, 1'b1, {1'b1, b[0]});
    cmd(0, c, 0, 1'b1, {1'b1, b[0]});
    cmd(0, c, 0, 1'b0, {1'b1, b[0]});
    cmd(0, c, 0, 1'b0, {1'b1, b[1]});
    cmd(1, c, 0, 1'b0, 9'h00D);
    i_line.stall <= 1'b1;
    for (int s = 0; s < 3; s++) begin
      cmd(2, c, 0, 1'b0, 9'h000);
      cmd(3, c, 0, 1'b0, 9'h000);
      i_line.offer(c, 8'h3C, ok);
      chk(9'(ok), 9'h001);
      put(c, 8'hC3);
      put(c, 8'h5A);
      cmd(2, c, s, 1'b0, 9'h000);
      if (s != 0) expTx[c].delete();
      cmd(1, c, 0, 1'b0, (s == 1) ? 9'h001 : 9'h000);
      cmd(0, c, 0, 1'b0, (s == 1) ? 9'h13C : 9'h000);
      cmd(3, c, 0, 1'b0, 9'h000);
      i_line.stall <= 1'b0;
      drain();
      i_line.stall <= 1'b1;
    end
    i_line.stall <= 1'b0;
    for (int i = 0; i < 24; i++) put($urandom_range(3), 8'($urandom));
    drain();
    for (int ch = 0; ch < 4; ch++) cmd(1, ch, 1, 1'b1, 9'h00F);
    cmd(3, 0, 0, 1'b0, 9'h000);
    repeat (2) @(posedge clock);
    chk(9'(expGet.size() + expQry.size()), 9'h000);
    chk(9'(expTx[0].size() + expTx[1].size()), 9'h000);
    chk(9'(expTx[2].size() + expTx[3].size()), 9'h000);
    chk(9'(rxSeen), 9'h012);
    give_verdict();
  end
endmodule : scb_channel_buffers_test

// [sim/scb_line_model.sv]
// line side model: offers receive bytes, takes send bytes with stalls
// assumes offer is called at a rising clock edge
`timescale 1ns/100ps
module scb_line_model (
  input wire logic clock,
  input wire logic [3:0] lineRxReady,
  output logic [3:0] lineRxValid = 4'h0,
  output logic [31:0] lineRxData = 32'h0,
  output logic [3:0] lineTxReady = 4'h0
);
  bit stall = 1'b0;
  // random take of send bytes, none while stalled
  always @(posedge clock) lineTxReady <= stall ? 4'h0 : 4'($urandom);
  // hold one byte until taken or refused for eight cycles
  task automatic offer(input int ch, input logic [7:0] b, output bit ok);
    int n;
    n = 0;
    lineRxValid[ch] <= 1'b1;
    lineRxData[8*ch+:8] <= b;
    do begin
      @(posedge clock);
      n++;
    end while (lineRxReady[ch] !== 1'b1 && n < 8);
    ok = (lineRxReady[ch] === 1'b1);
    lineRxValid[ch] <= 1'b0;
    lineRxData[8*ch+:8] <= ~b; // released line shows no stale byte
    @(posedge clock);
  endtask : offer
endmodule : scb_line_model
